// *** mss_map.svh ***
// Register map, field positions, reset values and timing figures of the motion sensor controls.
// Included by the axis formatter and the register bank modules; holds definitions only.
`ifndef MSS_MAP_SVH
`define MSS_MAP_SVH

`define MSS_ADDR_AXIS_SELECT 6'h27
`define MSS_ADDR_BANDWIDTH_RATE_CTRL 6'h2c
`define MSS_ADDR_POWER_CONTROL 6'h2d
`define MSS_ADDR_IRQ_ENABLE 6'h2e
`define MSS_ADDR_IRQ_ROUTE 6'h2f
`define MSS_ADDR_IRQ_FLAGS 6'h30
`define MSS_ADDR_OUTPUT_FORMAT 6'h31
`define MSS_ADDR_ACCEL_X_LOW 6'h32
`define MSS_ADDR_ACCEL_X_HIGH 6'h33
`define MSS_ADDR_ACCEL_Y_LOW 6'h34
`define MSS_ADDR_ACCEL_Y_HIGH 6'h35
`define MSS_ADDR_ACCEL_Z_LOW 6'h36
`define MSS_ADDR_ACCEL_Z_HIGH 6'h37

`define MSS_RESET_AXIS_SELECT 8'h00
`define MSS_RESET_BANDWIDTH_RATE_CTRL 8'h0a
`define MSS_RESET_POWER_CONTROL 8'h00
`define MSS_RESET_IRQ_ENABLE 8'h00
`define MSS_RESET_IRQ_ROUTE 8'h00
`define MSS_RESET_IRQ_FLAGS 8'h02
`define MSS_RESET_OUTPUT_FORMAT 8'h00

`define MSS_MASK_AXIS_SELECT 8'hff
`define MSS_MASK_BANDWIDTH_RATE_CTRL 8'h1f
`define MSS_MASK_POWER_CONTROL 8'h7f
`define MSS_MASK_IRQ 8'h9b
`define MSS_MASK_OUTPUT_FORMAT 8'hef

`define MSS_AXIS_MOTION 6:4
`define MSS_AXIS_STILL 2:0
`define MSS_BW_LOW_POWER 4
`define MSS_BANDWIDTH_RATE_CTRL 3:0
`define MSS_PWR_TWO_WIRE_OFF 6
`define MSS_PWR_CHAIN 5
`define MSS_PWR_AUTO_DOZE 4
`define MSS_PWR_RUN 3
`define MSS_PWR_DOZE 2
`define MSS_PWR_SLEEP_RATE 1:0
`define MSS_IRQ_NEW_SAMPLE 7
`define MSS_IRQ_MOTION 4
`define MSS_IRQ_STILL 3
`define MSS_IRQ_FILL 1
`define MSS_IRQ_OVERFLOW 0
`define MSS_FMT_SELF_TEST 7
`define MSS_FMT_THREE_WIRE 6
`define MSS_FMT_IRQ_INVERT 5
`define MSS_FMT_WIDE 3
`define MSS_FMT_LEFT 2
`define MSS_FMT_RANGE 1:0
`define MSS_FMT_RANGE_NO_CLIP 2'h3

`define MSS_CMD_READ 7
`define MSS_CMD_MULTI 6
`define MSS_CMD_ADDR 5:0
`define MSS_LAST_BIT 3'h7
`define MSS_BASE_BITS 10
`define MSS_OUT_BITS 16

`define MSS_SYS_CLK_HZ 40000000
`define MSS_SLEEP_BASE_HZ 8

`endif

// *** mss_pkg.sv ***
// Types shared by the motion sensor control modules.
// Assumes mss_map.svh supplies the numeric definitions.
package mss_pkg;
  typedef logic [5:0] mss_addr_t;
  typedef enum {MSS_SPI_CMD, MSS_SPI_DATA} mss_spi_phase_t;
  typedef enum {MSS_HUNT_STILL, MSS_HUNT_MOTION} mss_hunt_t;
endpackage

// *** mss_fmt_if.sv ***
// Output format settings carried from the register bank to the axis formatters.
// Assumes a single driver, the register bank, behind the src modport.
`timescale 1ns/1ps
interface mss_fmt_if;
  logic [1:0] range;
  logic wide;
  logic left;
  modport src (output range, output wide, output left);
  modport dst (input range, input wide, input left);
endinterface

// *** mss_axis_format.sv ***
// Formats one axis sample: scale, clip, justify.
// Assumes raw input at 1024 counts per g, within the widest range.
`timescale 1ns/1ps
`include "mss_map.svh"
module mss_axis_format
  import mss_pkg::*;
#(
  parameter int RAW_W = 16
)
(
  mss_fmt_if.dst cfg,
  input wire logic signed [RAW_W-1:0] raw,
  output logic [15:0] formatted
);
  logic signed [31:0] scaled;
  logic signed [31:0] top;
  int width;

  always_comb
  begin
    width = `MSS_BASE_BITS;
    scaled = 32'(raw);
    if (cfg.wide)
    begin
      width = `MSS_BASE_BITS + int'(cfg.range);
    end
    else
    begin
      scaled = scaled >>> cfg.range;
    end
    top = (32'sd1 <<< (width - 1)) - 32'sd1;
    // The widest range is left alone: the sensor cannot exceed it.
    if (cfg.range != `MSS_FMT_RANGE_NO_CLIP)
    begin
      if (scaled > top)
      begin
        scaled = top;
      end
      else if (scaled < -top - 32'sd1)
      begin
        scaled = -top - 32'sd1;
      end
    end
    if (cfg.left)
    begin
      formatted = 16'(scaled <<< (`MSS_OUT_BITS - width));
    end
    else
    begin
      formatted = 16'(scaled);
    end
  end
endmodule // mss_axis_format

// *** mss_motion_regs.sv ***
// Top of the sensor control bank: serial register port, detectors, interrupts, output data.
// Assumes sensor samples and level compares arrive on sys_clk; serial pins are asynchronous.
`timescale 1ns/1ps
`include "mss_map.svh"
module mss_motion_regs
  import mss_pkg::*;
#(
  parameter int SLEEP_BASE_CYCLES = `MSS_SYS_CLK_HZ / `MSS_SLEEP_BASE_HZ
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_sdi,
  output logic spi_sdo_out,
  output logic spi_sdo_oe,
  output logic spi_sdio_out,
  output logic spi_sdio_oe,
  output logic i2c_start_seen,
  input wire logic signed [15:0] raw_x,
  input wire logic signed [15:0] raw_y,
  input wire logic signed [15:0] raw_z,
  input wire logic raw_valid,
  input wire logic [2:0] motion_above,
  input wire logic [2:0] still_below,
  input wire logic [7:0] stillness_duration,
  input wire logic second_tick,
  input wire logic fifo_watermark,
  input wire logic fifo_overrun,
  output logic irq_pin_a,
  output logic irq_pin_b,
  output logic fifo_write,
  output logic [3:0] sample_rate_code,
  output logic reduced_power,
  output logic dozing,
  output logic sleep_sample_tick,
  output logic self_test_drive,
  output logic three_wire
);
  localparam int SLEEP_W = $clog2(SLEEP_BASE_CYCLES + 1);

  // Serial pin synchronisers; stage one feeds stage two only.
  logic [2:0] pin_s1, pin_s2, pin_s3;
  logic cs_idle, sclk_s, sdi_s, sclk_rise, sclk_fall, sdi_fall;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_s1 <= 3'h7;
      pin_s2 <= 3'h7;
      pin_s3 <= 3'h7;
    end
    else
    begin
      pin_s1 <= {spi_cs_n, spi_sclk, spi_sdi};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign cs_idle = pin_s2[2];
  assign sclk_s = pin_s2[1];
  assign sdi_s = pin_s2[0];
  assign sclk_rise = sclk_s & ~pin_s3[1];
  assign sclk_fall = ~sclk_s & pin_s3[1];
  assign sdi_fall = ~sdi_s & pin_s3[0];

  // Register state.
  logic [7:0] axis_sel, bandwidth_rate_ctrl, power_control, irq_en, irq_route, irq_flags, out_fmt;
  logic [7:0] next_axis_sel, next_bandwidth_rate_ctrl, next_power_control, next_irq_en, next_irq_route;
  logic [7:0] next_irq_flags, next_out_fmt;
  logic [15:0] accel [3];
  logic [15:0] next_accel [3];

  function automatic logic [7:0] read_mux(input mss_addr_t a);
    case (a)
      `MSS_ADDR_AXIS_SELECT: read_mux = axis_sel;
      `MSS_ADDR_BANDWIDTH_RATE_CTRL: read_mux = bandwidth_rate_ctrl;
      `MSS_ADDR_POWER_CONTROL: read_mux = power_control;
      `MSS_ADDR_IRQ_ENABLE: read_mux = irq_en;
      `MSS_ADDR_IRQ_ROUTE: read_mux = irq_route;
      `MSS_ADDR_IRQ_FLAGS: read_mux = irq_flags;
      `MSS_ADDR_OUTPUT_FORMAT: read_mux = out_fmt;
      `MSS_ADDR_ACCEL_X_LOW: read_mux = accel[0][7:0];
      `MSS_ADDR_ACCEL_X_HIGH: read_mux = accel[0][15:8];
      `MSS_ADDR_ACCEL_Y_LOW: read_mux = accel[1][7:0];
      `MSS_ADDR_ACCEL_Y_HIGH: read_mux = accel[1][15:8];
      `MSS_ADDR_ACCEL_Z_LOW: read_mux = accel[2][7:0];
      `MSS_ADDR_ACCEL_Z_HIGH: read_mux = accel[2][15:8];
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Serial port: mode 3, command byte of read, multi-byte and address bits.
  mss_spi_phase_t phase, next_phase;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] rx_shift, next_rx_shift, tx_shift, next_tx_shift, rx_byte;
  logic tx_bit, next_tx_bit, is_read, next_is_read, multi, next_multi;
  logic start_seen, next_start_seen;
  mss_addr_t addr, next_addr, step_addr, rd_addr;
  logic rd_strobe, wr_strobe;

  always_comb
  begin
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_rx_shift = rx_shift;
    next_tx_shift = tx_shift;
    next_tx_bit = tx_bit;
    next_is_read = is_read;
    next_multi = multi;
    next_addr = addr;
    rx_byte = {rx_shift[6:0], sdi_s};
    step_addr = multi ? addr + 6'h01 : addr;
    rd_addr = addr;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    // Start: data falls while clock is high and no four-wire frame is open.
    next_start_seen = sdi_fall & sclk_s & cs_idle & ~power_control[`MSS_PWR_TWO_WIRE_OFF];
    if (cs_idle)
    begin
      next_phase = MSS_SPI_CMD;
      next_bit_cnt = 3'h0;
    end
    else if (sclk_rise)
    begin
      next_bit_cnt = bit_cnt + 3'h1;
      next_rx_shift = rx_byte;
      if (bit_cnt == `MSS_LAST_BIT)
      begin
        if (phase == MSS_SPI_CMD)
        begin
          next_phase = MSS_SPI_DATA;
          next_is_read = rx_byte[`MSS_CMD_READ];
          next_multi = rx_byte[`MSS_CMD_MULTI];
          next_addr = rx_byte[`MSS_CMD_ADDR];
          rd_addr = rx_byte[`MSS_CMD_ADDR];
          rd_strobe = rx_byte[`MSS_CMD_READ];
        end
        else
        begin
          wr_strobe = ~is_read;
          next_addr = step_addr;
          rd_addr = step_addr;
          rd_strobe = is_read;
        end
        if (rd_strobe)
        begin
          next_tx_shift = read_mux(rd_addr);
        end
      end
    end
    else if (sclk_fall)
    begin
      next_tx_bit = tx_shift[7];
      next_tx_shift = {tx_shift[6:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase <= MSS_SPI_CMD;
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      tx_bit <= 1'b0;
      is_read <= 1'b0;
      multi <= 1'b0;
      addr <= 6'h00;
      start_seen <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
      tx_shift <= next_tx_shift;
      tx_bit <= next_tx_bit;
      is_read <= next_is_read;
      multi <= next_multi;
      addr <= next_addr;
      start_seen <= next_start_seen;
    end
  end

  assign i2c_start_seen = start_seen;
  assign three_wire = out_fmt[`MSS_FMT_THREE_WIRE];
  assign spi_sdo_out = tx_bit;
  assign spi_sdio_out = tx_bit;
  assign spi_sdo_oe = ~cs_idle & (phase == MSS_SPI_DATA) & is_read & ~three_wire;
  assign spi_sdio_oe = ~cs_idle & (phase == MSS_SPI_DATA) & is_read & three_wire;

  // Detectors, chaining and automatic doze.
  mss_hunt_t hunt, next_hunt;
  logic [7:0] still_secs, next_still_secs;
  logic still_done, next_still_done, asleep, next_asleep, sleep_due, next_sleep_due;
  logic measuring, motion_on, still_on, chained, motion_hit, still_all;
  logic motion_fire, still_fire, accept, data_rd, flags_rd;
  logic [SLEEP_W-1:0] base_cnt, next_base_cnt;
  logic [2:0] sleep_div, next_sleep_div;
  logic base_tick, next_sleep_tick, sleep_tick;
  logic [15:0] formatted [3];
  logic signed [15:0] raw_axis [3];

  assign measuring = power_control[`MSS_PWR_RUN];
  assign dozing = measuring & (power_control[`MSS_PWR_DOZE] | asleep);
  assign motion_on = measuring & |axis_sel[`MSS_AXIS_MOTION];
  assign still_on = measuring & |axis_sel[`MSS_AXIS_STILL] & ~dozing;
  assign chained = power_control[`MSS_PWR_CHAIN] & |axis_sel[`MSS_AXIS_MOTION]
    & |axis_sel[`MSS_AXIS_STILL];
  assign motion_hit = |(motion_above & axis_sel[`MSS_AXIS_MOTION]);
  assign still_all = &(still_below | ~axis_sel[`MSS_AXIS_STILL]);
  assign motion_fire = motion_on & motion_hit & (~chained | hunt == MSS_HUNT_MOTION);
  assign still_fire = still_on & still_all & ~still_done
    & (still_secs >= stillness_duration) & (~chained | hunt == MSS_HUNT_STILL);
  assign base_tick = (base_cnt == SLEEP_W'(SLEEP_BASE_CYCLES - 1));
  // Host frames freeze the output bytes, so samples landing then are dropped.
  assign accept = raw_valid & measuring & cs_idle & (~dozing | sleep_due);
  assign data_rd = rd_strobe & (rd_addr >= `MSS_ADDR_ACCEL_X_LOW)
    & (rd_addr <= `MSS_ADDR_ACCEL_Z_HIGH);
  assign flags_rd = rd_strobe & (rd_addr == `MSS_ADDR_IRQ_FLAGS);

  always_comb
  begin
    next_hunt = hunt;
    next_still_secs = still_secs;
    next_still_done = still_done;
    next_asleep = asleep;
    next_sleep_due = sleep_due;
    next_base_cnt = base_tick ? '0 : base_cnt + SLEEP_W'(1);
    next_sleep_div = sleep_div;
    next_sleep_tick = 1'b0;
    if (!still_on || !still_all)
    begin
      next_still_secs = 8'h00;
      next_still_done = 1'b0;
    end
    else if (second_tick && still_secs != 8'hff)
    begin
      next_still_secs = still_secs + 8'h01;
    end
    if (still_fire)
    begin
      next_still_done = 1'b1;
    end
    case (hunt)
      MSS_HUNT_STILL:
        if (still_fire)
        begin
          next_hunt = MSS_HUNT_MOTION;
        end
      MSS_HUNT_MOTION:
        if (motion_fire || !chained)
        begin
          next_hunt = MSS_HUNT_STILL;
          next_still_secs = 8'h00;
          next_still_done = 1'b0;
        end
      default: next_hunt = MSS_HUNT_STILL;
    endcase
    if (still_fire && chained && power_control[`MSS_PWR_AUTO_DOZE])
    begin
      next_asleep = 1'b1;
    end
    if (motion_fire || !power_control[`MSS_PWR_AUTO_DOZE] || !chained || !measuring)
    begin
      next_asleep = 1'b0;
    end
    if (base_tick)
    begin
      next_sleep_div = sleep_div + 3'h1;
      // Base tick runs at 8 Hz; the field halves it per step.
      if ((sleep_div & ((3'h1 << power_control[`MSS_PWR_SLEEP_RATE]) - 3'h1)) == 3'h0)
      begin
        next_sleep_tick = 1'b1;
      end
    end
    if (sleep_tick)
    begin
      next_sleep_due = 1'b1;
    end
    else if (accept || !dozing)
    begin
      next_sleep_due = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hunt <= MSS_HUNT_STILL;
      still_secs <= 8'h00;
      still_done <= 1'b0;
      asleep <= 1'b0;
      sleep_due <= 1'b0;
      base_cnt <= '0;
      sleep_div <= 3'h0;
      sleep_tick <= 1'b0;
    end
    else
    begin
      hunt <= next_hunt;
      still_secs <= next_still_secs;
      still_done <= next_still_done;
      asleep <= next_asleep;
      sleep_due <= next_sleep_due;
      base_cnt <= next_base_cnt;
      sleep_div <= next_sleep_div;
      sleep_tick <= next_sleep_tick;
    end
  end

  assign sleep_sample_tick = sleep_tick;

  // Output formatting, one formatter per axis.
  mss_fmt_if fmt_bus ();
  assign fmt_bus.range = out_fmt[`MSS_FMT_RANGE];
  assign fmt_bus.wide = out_fmt[`MSS_FMT_WIDE];
  assign fmt_bus.left = out_fmt[`MSS_FMT_LEFT];
  assign raw_axis[0] = raw_x;
  assign raw_axis[1] = raw_y;
  assign raw_axis[2] = raw_z;

  for (genvar g = 0; g < 3; g++)
  begin : g_axis
    mss_axis_format #(.RAW_W(16)) u_fmt (
      .cfg(fmt_bus),
      .raw(raw_axis[g]),
      .formatted(formatted[g])
    );
  end

  // Register bank, flags and interrupt pins.
  logic [7:0] irq_live, next_pins;
  logic [1:0] pins;

  always_comb
  begin
    next_axis_sel = axis_sel;
    next_bandwidth_rate_ctrl = bandwidth_rate_ctrl;
    next_power_control = power_control;
    next_irq_en = irq_en;
    next_irq_route = irq_route;
    next_out_fmt = out_fmt;
    for (int i = 0; i < 3; i++)
    begin
      next_accel[i] = accept ? formatted[i] : accel[i];
    end
    if (wr_strobe)
    begin
      case (addr)
        `MSS_ADDR_AXIS_SELECT: next_axis_sel = rx_byte & `MSS_MASK_AXIS_SELECT;
        `MSS_ADDR_BANDWIDTH_RATE_CTRL: next_bandwidth_rate_ctrl = rx_byte & `MSS_MASK_BANDWIDTH_RATE_CTRL;
        `MSS_ADDR_POWER_CONTROL: next_power_control = rx_byte & `MSS_MASK_POWER_CONTROL;
        `MSS_ADDR_IRQ_ENABLE: next_irq_en = rx_byte & `MSS_MASK_IRQ;
        `MSS_ADDR_IRQ_ROUTE: next_irq_route = rx_byte & `MSS_MASK_IRQ;
        `MSS_ADDR_OUTPUT_FORMAT: next_out_fmt = rx_byte & `MSS_MASK_OUTPUT_FORMAT;
        default: next_axis_sel = axis_sel;
      endcase
    end
    // A set in the same cycle as its clearing read wins.
    next_irq_flags = irq_flags;
    if (data_rd)
    begin
      next_irq_flags[`MSS_IRQ_NEW_SAMPLE] = 1'b0;
      next_irq_flags[`MSS_IRQ_FILL] = 1'b0;
      next_irq_flags[`MSS_IRQ_OVERFLOW] = 1'b0;
    end
    if (flags_rd)
    begin
      next_irq_flags[`MSS_IRQ_MOTION] = 1'b0;
      next_irq_flags[`MSS_IRQ_STILL] = 1'b0;
    end
    next_irq_flags[`MSS_IRQ_NEW_SAMPLE] |= accept & ~dozing;
    next_irq_flags[`MSS_IRQ_FILL] |= fifo_watermark;
    next_irq_flags[`MSS_IRQ_OVERFLOW] |= fifo_overrun;
    next_irq_flags[`MSS_IRQ_MOTION] |= motion_fire;
    next_irq_flags[`MSS_IRQ_STILL] |= still_fire;
    irq_live = irq_flags & irq_en;
    next_pins[0] = |(irq_live & ~irq_route);
    next_pins[1] = |(irq_live & irq_route);
    next_pins[7:2] = 6'h00;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      axis_sel <= `MSS_RESET_AXIS_SELECT;
      bandwidth_rate_ctrl <= `MSS_RESET_BANDWIDTH_RATE_CTRL;
      power_control <= `MSS_RESET_POWER_CONTROL;
      irq_en <= `MSS_RESET_IRQ_ENABLE;
      irq_route <= `MSS_RESET_IRQ_ROUTE;
      irq_flags <= `MSS_RESET_IRQ_FLAGS;
      out_fmt <= `MSS_RESET_OUTPUT_FORMAT;
      accel <= '{default: 16'h0000};
      pins <= 2'h0;
      fifo_write <= 1'b0;
    end
    else
    begin
      axis_sel <= next_axis_sel;
      bandwidth_rate_ctrl <= next_bandwidth_rate_ctrl;
      power_control <= next_power_control;
      irq_en <= next_irq_en;
      irq_route <= next_irq_route;
      irq_flags <= next_irq_flags;
      out_fmt <= next_out_fmt;
      accel <= next_accel;
      pins <= next_pins[1:0];
      fifo_write <= raw_valid & measuring & ~dozing;
    end
  end

  assign irq_pin_a = pins[0] ^ out_fmt[`MSS_FMT_IRQ_INVERT];
  assign irq_pin_b = pins[1] ^ out_fmt[`MSS_FMT_IRQ_INVERT];
  assign sample_rate_code = bandwidth_rate_ctrl[`MSS_BANDWIDTH_RATE_CTRL];
  assign reduced_power = bandwidth_rate_ctrl[`MSS_BW_LOW_POWER];
  assign self_test_drive = out_fmt[`MSS_FMT_SELF_TEST];

  sequence s_host_busy;
    !cs_idle ##1 !cs_idle;
  endsequence
  sequence s_motion_read;
    flags_rd && !motion_fire;
  endsequence

  AST_AXIS_EXCLUDED: assert property (@(posedge sys_clk) disable iff (!reset_n)
    axis_sel[`MSS_AXIS_MOTION] == 3'h0 |-> !motion_fire) else $error("motion fired, no axis");
  AST_STILL_ALL_AXES: assert property (@(posedge sys_clk) disable iff (!reset_n)
    still_fire |-> still_all && still_secs >= stillness_duration) else $error("early stillness");
  AST_RESET_RATE: assert property (@(posedge sys_clk)
    $rose(reset_n) |-> sample_rate_code == 4'ha) else $error("rate not at reset value");
  AST_BUSY_DISCARD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_host_busy |-> $stable(accel[0])) else $error("sample landed during frame");
  AST_TWO_WIRE_OFF: assert property (@(posedge sys_clk) disable iff (!reset_n)
    power_control[`MSS_PWR_TWO_WIRE_OFF] |=> !i2c_start_seen) else $error("start seen while off");
  AST_CHAIN_WAIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    chained && hunt == MSS_HUNT_STILL && !irq_flags[`MSS_IRQ_MOTION] |=>
    !irq_flags[`MSS_IRQ_MOTION]) else $error("motion before stillness");
  AST_AUTO_DOZE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    still_fire && chained && power_control[`MSS_PWR_AUTO_DOZE] && measuring
    && !$past(motion_fire) |=> asleep) else $error("no doze after stillness");
  AST_DOZE_QUIET: assert property (@(posedge sys_clk) disable iff (!reset_n)
    dozing && !accept |=> !fifo_write && !irq_flags[`MSS_IRQ_NEW_SAMPLE] ||
    $past(irq_flags[`MSS_IRQ_NEW_SAMPLE])) else $error("doze wrote a sample");
  AST_MOTION_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_motion_read |=> !irq_flags[`MSS_IRQ_MOTION]) else $error("motion flag not cleared");
  AST_PIN_LEVEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pins == 2'h0 |-> irq_pin_a == out_fmt[`MSS_FMT_IRQ_INVERT]) else $error("pin polarity");
endmodule // mss_motion_regs

// *** mss_host.sv ***
// Host model: serial master in mode 3, one command byte and then data bytes.
// Assumes calls start just after a sys_clk edge; sclk has a 200 ns period.
`timescale 1ns/1ps
module mss_host
(
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  output logic [7:0] rd_data,
  output logic rd_done
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi = 1'b1;
    rd_done = 1'b0;
  end
  // Data changes on the falling edge and is taken on the rising one.
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, input int n);
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < 8 * n + 8; i++)
    begin
      sclk = 1'b0;
      sdi = (i < 8) ? cmd[7 - i] : wd[7 - i % 8];
      #100 sclk = 1'b1;
      rd_data = {rd_data[6:0], sdo};
      if (i % 8 == 7 && i > 7 && cmd[7])
        rd_done = ~rd_done;
      #100;
    end
    cs_n = 1'b1;
    #100;
  endtask
  // A two-wire start: data falls while the clock idles high and select stays released.
  task automatic start_cond();
    sdi = 1'b1;
    #100 sdi = 1'b0;
    #100 sdi = 1'b1;
    #100;
  endtask
endmodule // mss_host

// *** testbench.sv ***
// Self-checking bench for the sensor control bank, driven through its serial port.
// Assumes the host model drives the serial pins; samples come from the bench.
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cs_n, sclk, sdi, sdo_out, sdo_oe, rd_done, pin_a, pin_b;
  logic fifo_w, low_pwr, doze, self_t, three_w, start_s;
  logic [3:0] rate;
  logic [2:0] motion = 3'h0;
  logic [2:0] still = 3'h0;
  logic raw_valid = 1'b0;
  logic overrun = 1'b0;
  logic [7:0] rd_data;
  logic signed [15:0] raw[3] = '{16'sh0, 16'sh0, 16'sh0};
  logic [31:0] seed = 32'ha5dd;
  logic [7:0] q[$];
  logic [5:0] wa[7] = '{6'h2c, 6'h2e, 6'h2f, 6'h31, 6'h2d, 6'h30, 6'h10};
  logic [7:0] wd[7] = '{8'hff, 8'hff, 8'hff, 8'hbf, 8'hc8, 8'hff, 8'hff};
  logic [7:0] wm[7] = '{8'h1f, 8'h9b, 8'h9b, 8'haf, 8'h48, 8'h02, 8'h00};
  int num_errors = 0;
  int checks = 0;
  int starts = 0;
  int writes = 0;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    starts <= starts + int'(start_s);
    writes <= writes + int'(fifo_w);
  end
  // A released data line shows the inverse of the last bit, so a late sample is caught.
  mss_host host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_oe ? sdo_out : ~sdo_out),
    .rd_data(rd_data), .rd_done(rd_done));
  mss_motion_regs #(.SLEEP_BASE_CYCLES(8)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo_out(sdo_out),
    .spi_sdo_oe(sdo_oe), .spi_sdio_out(), .spi_sdio_oe(), .i2c_start_seen(start_s),
    .raw_x(raw[0]), .raw_y(raw[1]), .raw_z(raw[2]), .raw_valid(raw_valid),
    .motion_above(motion), .still_below(still), .stillness_duration(8'h00),
    .second_tick(1'b0), .fifo_watermark(1'b0), .fifo_overrun(overrun),
    .irq_pin_a(pin_a), .irq_pin_b(pin_b), .fifo_write(fifo_w), .sample_rate_code(rate),
    .reduced_power(low_pwr), .dozing(doze), .sleep_sample_tick(),
    .self_test_drive(self_t), .three_wire(three_w));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(rd_done)
    if (q.size() > 0)
      check(rd_data, q.pop_front());
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk) #2;
    host.frame({2'b00, a}, d, 1);
  endtask
  task automatic rd(input logic [5:0] a, input int n);
    @(posedge sys_clk) #2;
    host.frame({1'b1, n > 1, a}, 8'h00, n);
  endtask
  task automatic pins(input logic a, input logic b);
    repeat (3) @(posedge sys_clk);
    #2;
    check({7'h0, pin_a}, {7'h0, a});
    check({7'h0, pin_b}, {7'h0, b});
  endtask
  // One-cycle pulse of the detector levels and the sample strobe.
  task automatic strobe(input logic [2:0] m, input logic [2:0] s, input logic v);
    @(posedge sys_clk) #2;
    motion = m;
    still = s;
    raw_valid = v;
    @(posedge sys_clk) #2;
    motion = 3'h0;
    still = 3'h0;
    raw_valid = 1'b0;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    #2 reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    q = {8'h0a, 8'h00, 8'h00, 8'h00, 8'h02};
    rd(6'h2c, 5);
    @(posedge sys_clk) #2 host.start_cond();
    check(8'(starts), 8'h01);
    foreach (wa[i])
    begin
      wr(wa[i], wd[i]);
      q.push_back(wm[i]);
      rd(wa[i], 1);
    end
    check({self_t, three_w, low_pwr, 1'b0, rate}, 8'haf);
    @(posedge sys_clk) #2 host.start_cond();
    check(8'(starts), 8'h01);
    wr(6'h2e, 8'h00);
    wr(6'h2f, 8'h00);
    wr(6'h31, 8'h0b);
    foreach (raw[i])
    begin
      seed = xs(seed);
      raw[i] = {{3{seed[12]}}, seed[12:0]};
    end
    strobe(3'h0, 3'h0, 1'b1);
    q = {8'h82};
    rd(6'h30, 1);
    q = {raw[0][7:0], raw[0][15:8], raw[1][7:0], raw[1][15:8], raw[2][7:0], raw[2][15:8]};
    rd(6'h32, 6);
    q = {8'h00};
    rd(6'h30, 1);
    wr(6'h2e, 8'h01);
    @(posedge sys_clk) #2 overrun = 1'b1;
    @(posedge sys_clk) #2 overrun = 1'b0;
    pins(1'b1, 1'b0);
    wr(6'h2f, 8'h01);
    pins(1'b0, 1'b1);
    wr(6'h31, 8'h2b);
    pins(1'b1, 1'b0);
    q = {8'h01, raw[0][7:0]};
    rd(6'h30, 1);
    rd(6'h32, 1);
    pins(1'b1, 1'b1);
    wr(6'h31, 8'h04);
    raw = '{16'sh0fff, 16'shf000, 16'sh0010};
    strobe(3'h0, 3'h0, 1'b1);
    q = {8'hc0, 8'h7f, 8'h00, 8'h80, 8'h00, 8'h04};
    rd(6'h32, 6);
    wr(6'h27, 8'h70);
    strobe(3'h2, 3'h0, 1'b0);
    q = {8'h10, 8'h00};
    rd(6'h30, 1);
    rd(6'h30, 1);
    wr(6'h27, 8'h77);
    wr(6'h2d, 8'h28);
    strobe(3'h4, 3'h0, 1'b0);
    q = {8'h00};
    rd(6'h30, 1);
    strobe(3'h0, 3'h7, 1'b0);
    strobe(3'h4, 3'h0, 1'b0);
    q = {8'h18};
    rd(6'h30, 1);
    wr(6'h2d, 8'h38);
    strobe(3'h0, 3'h7, 1'b0);
    check({7'h0, doze}, 8'h01);
    strobe(3'h1, 3'h0, 1'b0);
    check({7'h0, doze}, 8'h00);
    wr(6'h2d, 8'h00);
    wr(6'h2d, 8'h0c);
    check({7'h0, doze}, 8'h01);
    strobe(3'h0, 3'h0, 1'b1);
    q = {8'h18};
    rd(6'h30, 1);
    wr(6'h2d, 8'h00);
    wr(6'h2d, 8'h08);
    check(8'(writes), 8'h02);
    @(posedge sys_clk) #2 reset_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    #2 reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    q = {8'h0a, 8'h00, 8'h00, 8'h00, 8'h02};
    rd(6'h2c, 5);
    wrap_up();
  end
endmodule // testbench
